// File: rtl/mic_intc.v
// Interrupt controller: request flags, enables, entry and return through a memory stack
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "mic_regs.vh"
module mic_intc #(
    parameter NSRC = 8,
    parameter AW   = 8
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        port_a_pin_zero,
    input  wire        port_b_pin_five,
    input  wire        port_b_pin_zero,
    input  wire        port_a_pin_four,
    input  wire        adc_done,
    input  wire        sixteen_bit_timer,
    input  wire        analog_comparator,
    input  wire        pwm_generator_zero,
    input  wire        timer_two,
    input  wire        timer_three,
    input  wire        pin_pair_a_sel,
    input  wire        pin_pair_b_sel,
    input  wire [15:0] cpu_pc,
    input  wire        cpu_ready,
    input  wire [15:0] working_flags,
    output wire        cpu_irq_take,
    output reg  [15:0] cpu_pc_load,
    output reg         cpu_pc_load_valid,
    output reg  [15:0] working_restore,
    output reg         working_restore_valid,
    output wire        irq,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam ST_IDLE   = 3'd0;
    localparam ST_PUSH0  = 3'd1;
    localparam ST_PUSH1  = 3'd2;
    localparam ST_POP0   = 3'd3;
    localparam ST_POP1   = 3'd4;
    localparam ST_POP2   = 3'd5;

    // Edge detector selected by a two-bit mode
    function edge_hit;
        input [1:0] mode;
        input       prev;
        input       cur;
        begin
            case (mode)
                `MIC_EDGE_RISE: edge_hit = !prev && cur;
                `MIC_EDGE_FALL: edge_hit = prev && !cur;
                default:        edge_hit = prev ^ cur;
            endcase
        end
    endfunction

    reg  [NSRC-1:0] req_r;
    reg  [NSRC-1:0] enable_r;
    reg  [15:0]     edge_r;
    reg             gie_r;
    reg  [7:0]      sp_r;
    reg  [3:0]      status_r;
    reg  [3:0]      mask_r;
    reg  [NSRC-1:0] src_prev_r;
    reg  [2:0]      state_r;
    reg  [15:0]     hold_r;
    reg             pop_af_r;
    reg  [31:0]     awaddr_r;
    reg  [31:0]     wdata_r;
    reg  [3:0]      wstrb_r;
    reg             aw_have_r;
    reg             w_have_r;
    reg  [NSRC-1:0] src_now;
    reg  [NSRC-1:0] src_hit;
    reg  [3:0]      ev_set;
    reg             ram_we;
    reg  [AW-1:0]   ram_waddr;
    reg  [7:0]      ram_wdata;
    reg  [AW-1:0]   ram_raddr;
    wire [7:0]      ram_rdata;
    integer         i;

    wire wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire [7:0] wr_a = awaddr_r[7:0];
    wire cmd_wr = wr_go && (wr_a == `MIC_OFF_CMD) && wstrb_r[0];
    wire cmd_engint  = cmd_wr && wdata_r[`MIC_CMD_ENGINT];
    wire cmd_disgint = cmd_wr && wdata_r[`MIC_CMD_DISGINT];
    wire cmd_reti    = cmd_wr && wdata_r[`MIC_CMD_RETI];
    wire cmd_push    = cmd_wr && wdata_r[`MIC_CMD_PUSHAF];
    wire cmd_pop     = cmd_wr && wdata_r[`MIC_CMD_POPAF];
    wire idle        = (state_r == ST_IDLE);
    wire pending     = |(req_r & enable_r);

    assign cpu_irq_take  = idle && gie_r && pending && cpu_ready && !cmd_wr;
    // One write in flight: no new address or data while a response waits
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq           = |(status_r & mask_r);

    always @* begin
        // Pin pairs share a line; a select picks which pin drives it
        src_now = {timer_three, timer_two, pwm_generator_zero, analog_comparator,
                   sixteen_bit_timer, adc_done,
                   pin_pair_b_sel ? port_a_pin_four : port_b_pin_zero,
                   pin_pair_a_sel ? port_b_pin_five : port_a_pin_zero};
        for (i = 0; i < NSRC; i = i + 1) begin
            src_hit[i] = edge_hit(edge_r[2*i+:2], src_prev_r[i], src_now[i]);
        end
    end

    always @* begin
        ram_we    = 1'b0;
        ram_waddr = sp_r[AW-1:0];
        ram_wdata = 8'h00;
        ram_raddr = sp_r[AW-1:0];
        ev_set    = 4'h0;
        case (state_r)
            ST_PUSH0: begin
                ram_we    = 1'b1;
                ram_wdata = hold_r[7:0];
            end
            ST_PUSH1: begin
                ram_we    = 1'b1;
                ram_waddr = sp_r[AW-1:0] + 1'b1;
                ram_wdata = hold_r[15:8];
            end
            ST_POP0: begin
                ram_raddr = sp_r[AW-1:0] - 8'd2;
            end
            ST_POP1: begin
                ram_raddr = sp_r[AW-1:0] - 8'd1;
            end
            default: begin
                ram_raddr = sp_r[AW-1:0];
            end
        endcase
        if (cpu_irq_take) begin
            ev_set[`MIC_EV_ENTRY] = 1'b1;
        end
        if (idle && cmd_reti) begin
            ev_set[`MIC_EV_RETURN] = 1'b1;
        end
        if (idle && cmd_push) begin
            ev_set[`MIC_EV_PUSH] = 1'b1;
        end
        if (idle && cmd_pop) begin
            ev_set[`MIC_EV_POP] = 1'b1;
        end
    end

    mic_stack_ram #(
        .AW    (AW)
    ) u_stack (
        .aclk  (aclk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (ram_raddr),
        .rdata (ram_rdata)
    );

    // Set wins over a clear that lands in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            req_r      <= {NSRC{1'b0}};
            src_prev_r <= {NSRC{1'b0}};
            status_r   <= 4'h0;
        end else begin
            src_prev_r <= src_now;
            // Entry does not touch the flags; only software clears them
            if (wr_go && wr_a == `MIC_OFF_REQ && wstrb_r[0]) begin
                req_r <= (req_r & wdata_r[NSRC-1:0]) | src_hit;
            end else begin
                req_r <= req_r | src_hit;
            end
            if (wr_go && wr_a == `MIC_OFF_STATUS && wstrb_r[0]) begin
                status_r <= (status_r & ~wdata_r[3:0]) | ev_set;
            end else begin
                status_r <= status_r | ev_set;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r               <= ST_IDLE;
            gie_r                 <= 1'b0;
            sp_r                  <= `MIC_RST_BYTE;
            hold_r                <= `MIC_RST_PC;
            pop_af_r              <= 1'b0;
            cpu_pc_load           <= `MIC_RST_PC;
            cpu_pc_load_valid     <= 1'b0;
            working_restore       <= 16'h0000;
            working_restore_valid <= 1'b0;
        end else begin
            cpu_pc_load_valid     <= 1'b0;
            working_restore_valid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cpu_irq_take) begin
                        hold_r  <= cpu_pc;
                        gie_r   <= 1'b0;
                        state_r <= ST_PUSH0;
                    end else if (cmd_reti || cmd_pop) begin
                        pop_af_r <= cmd_pop && !cmd_reti;
                        state_r  <= ST_POP0;
                    end else if (cmd_push) begin
                        hold_r  <= working_flags;
                        state_r <= ST_PUSH0;
                        pop_af_r <= 1'b1;
                    end else begin
                        if (cmd_engint) begin
                            gie_r <= 1'b1;
                        end else if (cmd_disgint) begin
                            gie_r <= 1'b0;
                        end
                        if (wr_go && wr_a == `MIC_OFF_CTRL && wstrb_r[0]) begin
                            gie_r <= wdata_r[`MIC_CTRL_GIE];
                        end
                        // Odd values are accepted; software keeps bit 0 clear
                        if (wr_go && wr_a == `MIC_OFF_SP && wstrb_r[0]) begin
                            sp_r <= wdata_r[7:0];
                        end
                    end
                end
                ST_PUSH0: begin
                    state_r <= ST_PUSH1;
                end
                ST_PUSH1: begin
                    sp_r    <= sp_r + `MIC_SP_STEP;
                    state_r <= ST_IDLE;
                    if (!pop_af_r) begin
                        cpu_pc_load       <= `MIC_VECTOR;
                        cpu_pc_load_valid <= 1'b1;
                    end
                    pop_af_r <= 1'b0;
                end
                ST_POP0: begin
                    state_r <= ST_POP1;
                end
                ST_POP1: begin
                    hold_r[7:0] <= ram_rdata;
                    state_r     <= ST_POP2;
                end
                default: begin
                    sp_r    <= sp_r - `MIC_SP_STEP;
                    state_r <= ST_IDLE;
                    if (pop_af_r) begin
                        working_restore       <= {ram_rdata, hold_r[7:0]};
                        working_restore_valid <= 1'b1;
                    end else begin
                        cpu_pc_load       <= {ram_rdata, hold_r[7:0]};
                        cpu_pc_load_valid <= 1'b1;
                        gie_r             <= 1'b1;
                    end
                    pop_af_r <= 1'b0;
                end
            endcase
        end
    end

    // Register bus slave; stack commands are dropped unless idle
    always @(posedge aclk) begin
        if (!aresetn) begin
            enable_r     <= {NSRC{1'b0}};
            edge_r       <= 16'h0000;
            mask_r       <= 4'h0;
            awaddr_r     <= 32'h0000_0000;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && !aw_have_r) begin
                awaddr_r  <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_r) begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                if (wr_a == `MIC_OFF_ENABLE) begin
                    if (wstrb_r[0]) enable_r <= wdata_r[NSRC-1:0];
                end else if (wr_a == `MIC_OFF_EDGE) begin
                    if (wstrb_r[0]) edge_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) edge_r[15:8] <= wdata_r[15:8];
                end else if (wr_a == `MIC_OFF_MASK) begin
                    if (wstrb_r[0]) mask_r <= wdata_r[3:0];
                end else if (wr_a == `MIC_OFF_REQ || wr_a == `MIC_OFF_CTRL || wr_a == `MIC_OFF_SP ||
                             wr_a == `MIC_OFF_STATUS || wr_a == `MIC_OFF_CMD) begin
                    s_axi_bresp <= 2'b00;
                end else begin
                    s_axi_bresp <= 2'b10;
                end
                if (awaddr_r[31:8] != 24'h0) begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[31:8] != 24'h0) begin
                s_axi_rresp <= 2'b10;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_REQ) begin
                s_axi_rdata[NSRC-1:0] <= req_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_ENABLE) begin
                s_axi_rdata[NSRC-1:0] <= enable_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_EDGE) begin
                s_axi_rdata[15:0] <= edge_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_CTRL) begin
                s_axi_rdata[`MIC_CTRL_GIE] <= gie_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_SP) begin
                s_axi_rdata[7:0] <= sp_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_PC) begin
                s_axi_rdata[15:0] <= cpu_pc_load;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_SAVED_AF) begin
                s_axi_rdata[15:0] <= working_restore;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_STATUS) begin
                s_axi_rdata[3:0] <= status_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_MASK) begin
                s_axi_rdata[3:0] <= mask_r;
            end else if (s_axi_araddr[7:0] == `MIC_OFF_CMD) begin
                s_axi_rdata[2:0] <= state_r;
            end else begin
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // mic_intc

// File: include/mic_regs.vh
// Register offsets, field positions, reset values and codes of the interrupt controller
// Notes on behaviour
// - Eight request lines from pins, converter, timers
// - Per-line enable bit gates each line's servicing
// - Hardware sets flags; software write clears them
// - Edge select: rising, falling or both
// - Global enable set and cleared by commands
// - Flags set even while line disabled
// - Entry stores counter at stack pointer, adds two
// - Entry clears global enable automatically
// - Entry continues at fixed vector 0x010
// - Return reloads counter, stack pointer minus two
// - Return sets global enable again
// - Request register readable, shows pending sources
// - Push and pop save accumulator and flags
`ifndef MIC_REGS_VH
`define MIC_REGS_VH
`define MIC_OFF_REQ      8'h00
`define MIC_OFF_ENABLE   8'h04
`define MIC_OFF_EDGE     8'h08
`define MIC_OFF_CTRL     8'h0c
`define MIC_OFF_SP       8'h10
`define MIC_OFF_PC       8'h14
`define MIC_OFF_SAVED_AF 8'h18
`define MIC_OFF_STATUS   8'h1c
`define MIC_OFF_MASK     8'h20
`define MIC_OFF_CMD      8'h24
`define MIC_CTRL_GIE     0
`define MIC_CMD_ENGINT   0
`define MIC_CMD_DISGINT  1
`define MIC_CMD_RETI     2
`define MIC_CMD_PUSHAF   3
`define MIC_CMD_POPAF    4
`define MIC_EDGE_BOTH    2'b00
`define MIC_EDGE_RISE    2'b01
`define MIC_EDGE_FALL    2'b10
`define MIC_VECTOR       16'h0010
`define MIC_SP_STEP      8'h02
`define MIC_RST_BYTE     8'h00
`define MIC_RST_PC       16'h0000
`define MIC_EV_ENTRY     0
`define MIC_EV_RETURN    1
`define MIC_EV_PUSH      2
`define MIC_EV_POP       3
`endif

// File: rtl/mic_stack_ram.v
// Byte-wide stack memory with registered read data
`timescale 1ns/1ns
module mic_stack_ram #(
    parameter AW = 8
) (
    input  wire          aclk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    input  wire [AW-1:0] raddr,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // mic_stack_ram

// File: dv/mic_intc_properties.sv
// Port assertions for the interrupt controller
`timescale 1ns/1ns
module mic_intc_properties (
    input wire        aclk,
    input wire        aresetn,
    input wire        cpu_ready,
    input wire        cpu_irq_take,
    input wire [15:0] cpu_pc_load,
    input wire        cpu_pc_load_valid,
    input wire        working_restore_valid,
    input wire        irq,
    input wire        s_axi_awready,
    input wire        s_axi_arready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_TAKE_AT_BOUNDARY: assert property (cpu_irq_take |-> cpu_ready)
        else $error("entry taken off an instruction boundary");
    AST_ENTRY_VECTOR: assert property (cpu_irq_take |-> ##[1:5] (cpu_pc_load_valid && cpu_pc_load == 16'h0010))
        else $error("entry did not load the vector");
    AST_NO_RETAKE: assert property (cpu_irq_take |=> !cpu_irq_take [*4])
        else $error("second entry while the first is saved");
    AST_LOAD_PULSE: assert property (cpu_pc_load_valid |=> !cpu_pc_load_valid)
        else $error("load pulse longer than one cycle");
    AST_POP_NO_LOAD: assert property (working_restore_valid |-> !cpu_pc_load_valid)
        else $error("restore came with a counter load");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    AST_WRITE_PENDING: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("second write accepted while one pending");
    AST_READ_PENDING: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted while one pending");
    COV_ENTRY: cover property (cpu_irq_take);
    COV_POP: cover property (working_restore_valid);
    COV_IRQ: cover property ($rose(irq));
endmodule // mic_intc_properties

bind mic_intc mic_intc_properties u_props (.aclk(aclk), .aresetn(aresetn), .cpu_ready(cpu_ready),
    .cpu_irq_take(cpu_irq_take), .cpu_pc_load(cpu_pc_load), .cpu_pc_load_valid(cpu_pc_load_valid),
    .working_restore_valid(working_restore_valid), .irq(irq), .s_axi_awready(s_axi_awready),
    .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: dv/mic_cpu_model.sv
// Core stand-in: program counter, instruction boundary, working registers
`timescale 1ns/1ns
module mic_cpu_model (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        slow,
    input  wire [15:0] cpu_pc_load,
    input  wire        cpu_pc_load_valid,
    input  wire [15:0] working_restore,
    input  wire        working_restore_valid,
    output reg  [15:0] cpu_pc,
    output wire        cpu_ready,
    output wire [15:0] working_flags
);
    reg     [1:0]  phase_r;
    reg     [15:0] restored;
    integer        loads;
    // Slow core reaches a boundary only every fourth cycle
    assign cpu_ready     = !slow || (phase_r == 2'b11);
    assign working_flags = 16'h5aa5;
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_r  <= 2'b00;
            cpu_pc   <= 16'h0abc;
            loads    <= 0;
            restored <= 16'h0000;
        end else begin
            phase_r <= phase_r + 2'b01;
            if (cpu_pc_load_valid) begin
                cpu_pc <= cpu_pc_load;
                loads  <= loads + 1;
            end
            if (working_restore_valid) restored <= working_restore;
        end
    end
endmodule // mic_cpu_model

// File: dv/mic_intc_bench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin errors = errors + 1; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module mic_intc_bench;
    reg         aclk    = 1'b0;
    reg         aresetn = 1'b0;
    reg  [9:0]  src     = 10'h000;
    reg         sel     = 1'b0;
    reg         slow    = 1'b0;
    reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid, ldv, rsv, irq, rdy;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] pc, ld, wf, rs;
    integer     errors = 0, compares = 0, i, m, ln;
    initial forever #5 aclk = ~aclk;
    mic_cpu_model i_mic_cpu_model (.aclk(aclk), .aresetn(aresetn), .slow(slow), .cpu_pc_load(ld),
        .cpu_pc_load_valid(ldv), .working_restore(rs), .working_restore_valid(rsv), .cpu_pc(pc),
        .cpu_ready(rdy), .working_flags(wf));
    mic_intc i_mic_intc (.aclk(aclk), .aresetn(aresetn), .port_a_pin_zero(src[0]), .port_b_pin_five(src[1]),
        .port_b_pin_zero(src[2]), .port_a_pin_four(src[3]), .adc_done(src[4]), .sixteen_bit_timer(src[5]),
        .analog_comparator(src[6]), .pwm_generator_zero(src[7]), .timer_two(src[8]), .timer_three(src[9]),
        .pin_pair_a_sel(sel), .pin_pair_b_sel(sel), .cpu_pc(pc), .cpu_ready(rdy), .working_flags(wf),
        .cpu_irq_take(), .cpu_pc_load(ld), .cpu_pc_load_valid(ldv), .working_restore(rs),
        .working_restore_valid(rsv), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task report_and_stop;
        begin
            $display("errors %0d compares %0d", errors, compares);
            if (errors == 0 && compares > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task wr(input [31:0] a, input [31:0] d, input [1:0] er);
        integer n;
        reg     ok;
        begin
            awaddr  <= a;
            wdata   <= d;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            n = 0;
            ok = 1'b0;
            while (!ok && n < 40) begin
                @(posedge aclk);
                n = n + 1;
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) begin
                    ok = 1'b1;
                    `CHK("bresp", er, bresp)
                end
            end
            if (!ok) begin
                errors = errors + 1;
                report_and_stop;
            end
        end
    endtask

    task rdchk(input [31:0] a, input [31:0] e, input [1:0] er);
        integer n;
        reg     ok;
        begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            n = 0;
            ok = 1'b0;
            while (!ok && n < 40) begin
                @(posedge aclk);
                n = n + 1;
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) begin
                    ok = 1'b1;
                    `CHK("rresp", er, rresp)
                    if (er == 2'b00) `CHK($sformatf("register %h", a), e, rdata)
                end
            end
            if (!ok) begin
                errors = errors + 1;
                report_and_stop;
            end
        end
    endtask

    task wait_ld(input integer t);
        integer n;
        begin
            n = 0;
            while (i_mic_cpu_model.loads < t && n < 200) begin
                @(posedge aclk);
                n = n + 1;
            end
            if (i_mic_cpu_model.loads < t) begin
                errors = errors + 1;
                report_and_stop;
            end
        end
    endtask

    initial begin
        tick(6);
        aresetn <= 1'b1;
        tick(1);
        rdchk(32'h00, 32'h0, 2'b00);
        rdchk(32'h0c, 32'h0, 2'b00);
        rdchk(32'h28, 32'h0, 2'b10);
        wr(32'h28, 32'h1, 2'b10);
        // Every source, both pins of each pair, default both-edge mode
        for (i = 0; i < 10; i = i + 1) begin
            ln = (i < 4) ? i / 2 : i - 2;
            sel <= i[0];
            tick(1);
            src[i] <= 1'b1;
            tick(3);
            rdchk(32'h00, 32'h1 << ln, 2'b00);
            src[i] <= 1'b0;
            tick(3);
            wr(32'h00, ~(32'h1 << ln), 2'b00);
            rdchk(32'h00, 32'h0, 2'b00);
        end
        for (m = 0; m < 3; m = m + 1) begin
            wr(32'h08, m << 4, 2'b00);
            src[4] <= 1'b1;
            tick(3);
            rdchk(32'h00, (m != 2) ? 32'h4 : 32'h0, 2'b00);
            wr(32'h00, 32'h0, 2'b00);
            src[4] <= 1'b0;
            tick(3);
            rdchk(32'h00, (m != 1) ? 32'h4 : 32'h0, 2'b00);
            wr(32'h00, 32'h0, 2'b00);
        end
        // Pending flag on a disabled line, then enabled with a slow core
        wr(32'h10, 32'h40, 2'b00);
        wr(32'h24, 32'h1, 2'b00);
        rdchk(32'h0c, 32'h1, 2'b00);
        slow <= 1'b1;
        src[5] <= 1'b1;
        tick(6);
        rdchk(32'h00, 32'h8, 2'b00);
        `CHK("loads", 0, i_mic_cpu_model.loads)
        wr(32'h04, 32'h8, 2'b00);
        wait_ld(1);
        `CHK("pc", 16'h0010, pc)
        rdchk(32'h10, 32'h42, 2'b00);
        rdchk(32'h0c, 32'h0, 2'b00);
        rdchk(32'h00, 32'h8, 2'b00);
        slow <= 1'b0;
        wr(32'h24, 32'h8, 2'b00);
        tick(6);
        rdchk(32'h10, 32'h44, 2'b00);
        wr(32'h24, 32'h10, 2'b00);
        tick(6);
        `CHK("restore", 16'h5aa5, i_mic_cpu_model.restored)
        rdchk(32'h18, 32'h5aa5, 2'b00);
        rdchk(32'h10, 32'h42, 2'b00);
        wr(32'h00, 32'hf7, 2'b00);
        wr(32'h24, 32'h4, 2'b00);
        wait_ld(2);
        `CHK("pc", 16'h0abc, pc)
        rdchk(32'h14, 32'h0abc, 2'b00);
        rdchk(32'h10, 32'h40, 2'b00);
        rdchk(32'h0c, 32'h1, 2'b00);
        wr(32'h24, 32'h2, 2'b00);
        rdchk(32'h0c, 32'h0, 2'b00);
        wr(32'h0c, 32'h1, 2'b00);
        rdchk(32'h0c, 32'h1, 2'b00);
        wr(32'h0c, 32'h0, 2'b00);
        rdchk(32'h0c, 32'h0, 2'b00);
        rdchk(32'h24, 32'h0, 2'b00);
        // Event status, mask and interrupt line
        rdchk(32'h1c, 32'hf, 2'b00);
        `CHK("irq", 1'b0, irq)
        wr(32'h20, 32'h1, 2'b00);
        `CHK("irq", 1'b1, irq)
        wr(32'h1c, 32'h1, 2'b00);
        rdchk(32'h1c, 32'he, 2'b00);
        `CHK("irq", 1'b0, irq)
        report_and_stop;
    end
endmodule // mic_intc_bench
